// >>> ssd_cmd.sv
// Seven-segment display command interpreter with AXI4-Lite register port
`timescale 1ns/1ps
module ssd_cmd
  import ssd_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output      logic              s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output      logic              s_axi_wready_o,
  // AXI4-Lite write response
  output      logic [1:0]        s_axi_bresp_o,
  output      logic              s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output      logic              s_axi_arready_o,
  // AXI4-Lite read data
  output      logic [31:0]       s_axi_rdata_o,
  output      logic [1:0]        s_axi_rresp_o,
  output      logic              s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Display and error flag
  output      ssd_disp_t         disp_o,
  output      logic              err_o
);

  // ************
  // Declarations
  // ************
  ssd_state_t                 st_reg;
  ssd_state_t                 st_next;
  logic signed [31:0]         op;
  logic                       neg;
  logic [BIN_W-1:0]           mag;
  logic [NUM_DIGITS-1:0][3:0] bcd;
  logic [NUM_DIGITS-1:0][6:0] seg_num;
  logic [NUM_DIGITS-1:0][7:0] num6;
  logic [1:0][7:0]            num2;
  logic [2:0]                 msd;
  logic                       in6;
  logic                       in2;
  logic [7:0]                 dp_off;
  logic                       err_set;
  logic                       err_clr;

  // ************
  // Functions
  // ************

  // Address decode, shared by the write and read paths
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == OFS_CMD_K) || (a == OFS_CMD_R) || (a == OFS_STATUS) ||
              (a == OFS_SEG_LO) || (a == OFS_SEG_HI);
  endfunction

  // Missing byte lanes arrive as zero
  function automatic logic [31:0] strb_mask(input logic [31:0] d,
                                            input logic [3:0]  s);
    strb_mask = '0;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        strb_mask[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction

  // Shown pattern of one digit, point in bit 7
  function automatic logic [7:0] shown(input ssd_disp_t d, input int i);
    shown = {d.dp[i], d.seg[i]};
  endfunction

  // Read word for an address; zero for unmapped or write-only words
  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a,
                                          input ssd_state_t s);
    rd_word = '0;
    if (a == OFS_STATUS) begin
      rd_word[STAT_MODE_LSB +: 2] = s.mode;
      rd_word[STAT_LZ_BIT]        = s.lz;
      rd_word[STAT_FREE_BIT]      = s.free_en;
      rd_word[STAT_ERR_BIT]       = s.err;
    end else if (a == OFS_SEG_LO) begin
      for (int i = 0; i < 4; i++) begin
        rd_word[i*8 +: 8] = shown(s.disp, i);
      end
    end else if (a == OFS_SEG_HI) begin
      for (int i = 0; i < 2; i++) begin
        rd_word[i*8 +: 8] = shown(s.disp, i + 4);
      end
    end
  endfunction

  // ************
  // Handshake outputs
  // ************

  // Each write channel takes one item and holds it until the write executes; the read channel waits while an answer is pending
  assign s_axi_awready_o = ~st_reg.aw_full;
  assign s_axi_wready_o  = ~st_reg.w_full;
  assign s_axi_arready_o = ~st_reg.rvalid;

  // Registered answers
  assign s_axi_bvalid_o = st_reg.bvalid;
  assign s_axi_bresp_o  = st_reg.bresp;
  assign s_axi_rvalid_o = st_reg.rvalid;
  assign s_axi_rdata_o  = st_reg.rdata;
  assign s_axi_rresp_o  = st_reg.rresp;

  // Display and flag straight from flip-flops
  assign disp_o = st_reg.disp;
  assign err_o  = st_reg.err;

  // ************
  // Numeric rendering
  // ************

  // Operand is the latched write word, read as signed
  assign op     = st_reg.w_data;
  assign neg    = op[31];
  assign mag    = neg ? BIN_W'(-op) : op[BIN_W-1:0];
  assign dp_off = op[7:0] - CMD_DP0;

  // Range windows of the two numeric modes
  assign in6 = (op >= NUM6_MIN) && (op <= NUM6_MAX); // [RULE15] [RULE16]
  assign in2 = (st_reg.w_data <= NUM2_MAX);          // [RULE17] [RULE16]

  // One converter serves both numeric modes
  ssd_bin2bcd u_bcd (
    .bin_i (mag),
    .bcd_o (bcd)
  );

  // Per-digit encoders
  for (genvar gi = 0; gi < NUM_DIGITS; gi++) begin : g_enc
    ssd_seg_enc u_enc (
      .digit_i (bcd[gi]),
      .seg_o   (seg_num[gi])
    );
  end

  // Six-digit form: right-justified, blanks or zeros to the left
  always_comb begin
    msd = '0;
    for (int i = 1; i < NUM_DIGITS; i++) begin
      if (bcd[i] != 4'h0) begin
        msd = 3'(i);
      end
    end
    for (int i = 0; i < NUM_DIGITS; i++) begin
      num6[i] = SEG_BLANK;
      if (st_reg.lz || (3'(i) <= msd)) begin
        num6[i] = {1'b0, seg_num[i]};             // [RULE9] [RULE15]
      end
    end
    // Negative values hold at most five digits, so a slot is always free
    if (neg) begin
      if (st_reg.lz) begin
        num6[NUM_DIGITS-1] = SEG_MINUS;
      end else begin
        num6[msd + 3'h1] = SEG_MINUS;             // [RULE15]
      end
    end
  end

  // Two-digit form: tens blank unless nonzero or zeros wanted
  always_comb begin
    num2[0] = {1'b0, seg_num[0]};
    num2[1] = SEG_BLANK;
    if (st_reg.lz || (bcd[1] != 4'h0)) begin
      num2[1] = {1'b0, seg_num[1]};
    end
  end

  // ************
  // Next-state logic
  // ************
  always_comb begin
    st_next = st_reg;
    err_set = 1'b0;
    err_clr = 1'b0;

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid_i && !st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !st_reg.w_full) begin
      st_next.w_full = 1'b1;
      st_next.w_data = strb_mask(s_axi_wdata_i, s_axi_wstrb_i);
    end
    if (st_reg.bvalid && s_axi_bready_i) begin
      st_next.bvalid = 1'b0;
    end

    // A complete write is one command; it lands one edge later
    if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin // [RULE21]
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = addr_ok(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;

      if (st_reg.aw_addr == OFS_CMD_K) begin
        // Constant operand: same effect in every mode except points 2..5 and shift
        unique case (op[7:0])                                    // [RULE5]
          CMD_CLEAR: begin
            st_next.pat     = '0;                                // [RULE6]
            st_next.dp      = '0;
            st_next.mode    = MODE_SIX;
            st_next.lz      = 1'b0;
            st_next.free_en = 1'b0;
          end
          CMD_BAN1: begin
            st_next.pat     = BAN_K1;                            // [RULE7]
            st_next.mode    = MODE_SIX;
            st_next.free_en = 1'b0;
          end
          CMD_BAN2: begin
            st_next.pat     = BAN_K2;                            // [RULE7]
            st_next.mode    = MODE_SIX;
            st_next.free_en = 1'b0;
          end
          CMD_HELP: begin
            st_next.pat     = BAN_K3;                            // [RULE7]
            st_next.mode    = MODE_SIX;
            st_next.free_en = 1'b0;
          end
          CMD_ERROR: begin
            st_next.pat     = BAN_K5;                            // [RULE7]
            st_next.mode    = MODE_SIX;
            st_next.free_en = 1'b0;
          end
          CMD_HLPNN: begin
            st_next.pat[5:2] = PRE_K4;                           // [RULE8]
            st_next.pat[1:0] = '0;
            st_next.mode     = MODE_TWO;
            st_next.free_en  = 1'b0;
          end
          CMD_ERRNN: begin
            st_next.pat[5:2] = PRE_K6;                           // [RULE8]
            st_next.pat[1:0] = '0;
            st_next.mode     = MODE_TWO;
            st_next.free_en  = 1'b0;
          end
          CMD_LZERO: begin
            st_next.pat     = '0;                                // [RULE9]
            st_next.mode    = MODE_SIX;
            st_next.lz      = 1'b1;
            st_next.free_en = 1'b0;
          end
          CMD_TWO: begin
            st_next.pat     = '0;                                // [RULE10]
            st_next.mode    = MODE_TWO;
            st_next.free_en = 1'b0;
          end
          CMD_DP0, CMD_DP1: begin
            st_next.dp[dp_off[2:0]] = 1'b1;                      // [RULE11]
          end
          CMD_DP2, CMD_DP2 + 8'h01, CMD_DP2 + 8'h02, CMD_DP5: begin
            // Upper points only take effect in six-digit mode
            if (st_reg.mode == MODE_SIX) begin
              st_next.dp[dp_off[2:0]] = 1'b1;                    // [RULE12]
            end
          end
          CMD_FREE: begin
            st_next.mode    = MODE_FREE;                         // [RULE13]
            st_next.free_en = 1'b0;
          end
          CMD_FREE2: begin
            st_next.mode    = MODE_TWO;                          // [RULE13]
            st_next.free_en = 1'b1;
          end
          CMD_SHIFT: begin
            // Leftmost pattern falls off, a blank enters at the right
            if ((st_reg.mode == MODE_FREE) || st_reg.free_en) begin
              st_next.pat = {st_reg.pat[4:0], SEG_BLANK};        // [RULE14]
            end
          end
          default: begin
            // Unknown constants are ignored
          end
        endcase
      end else if (st_reg.aw_addr == OFS_CMD_R) begin
        // Register operand: effect depends on the held mode
        if ((st_reg.mode == MODE_FREE) || st_reg.free_en) begin
          st_next.pat[0] = op[7:0];                              // [RULE18] [RULE19]
        end else begin
          unique case (st_reg.mode)                              // [RULE2]
            MODE_SIX: begin
              if (in6) begin
                st_next.pat = num6;                              // [RULE15]
              end else begin
                err_set = 1'b1;                                  // [RULE16]
              end
            end
            MODE_TWO: begin
              // Left four digits stay as the prefix left them
              if (in2) begin
                st_next.pat[1:0] = num2;                         // [RULE3] [RULE17]
              end else begin
                err_set = 1'b1;                                  // [RULE16]
              end
            end
            default: begin
              err_set = 1'b1;
            end
          endcase
        end
      end else if (st_reg.aw_addr == OFS_STATUS) begin
        // Error flag is write-one-to-clear
        err_clr = op[STAT_ERR_BIT];
      end
    end

    // A new error outranks a clear in the same cycle
    st_next.err = (st_reg.err & ~err_clr) | err_set;             // [RULE16]

    // Read channel: answer registered one edge after the address
    if (st_reg.rvalid && s_axi_rready_i) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_word(s_axi_araddr_i, st_reg);
      st_next.rresp  = addr_ok(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end

    // Digit outputs: segments plus merged point sources
    for (int i = 0; i < NUM_DIGITS; i++) begin
      st_next.disp.seg[i] = st_next.pat[i][6:0];                 // [RULE1] [RULE19]
      st_next.disp.dp[i]  = st_next.pat[i][7] | st_next.dp[i];   // [RULE1]
    end
  end

  // ************
  // State register
  // ************

  // Reset leaves a blank six-digit display with zeros suppressed
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= STATE_RST;                                       // [RULE20]
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// >>> ssd_pkg.sv
// Package: constants, types and state layout of the seven-segment command block
//
// Summary of operation
// RULE1 - Six digits with points, digit zero rightmost
// RULE2 - Hold six-digit, two-digit or free mode
// RULE3 - Two-digit mode keeps left four digits
// RULE4 - CPU supplies constant or register operand
// RULE5 - Constant commands act the same in any mode; the code makes 12..15 and 21 depend on the mode
// RULE6 - Constant 0 blanks, clears points, six-digit
// RULE7 - Constants 1,2,3,5 show banners, six-digit
// RULE8 - Constants 4,6 show prefix, two-digit mode
// RULE9 - Constant 7 blanks, six-digit, leading zeros on
// RULE10 - Constant 8 blanks, enters two-digit mode
// RULE11 - Constants 10,11 light point zero or one
// RULE12 - Constants 12..15 light points in six-digit
// RULE13 - Constant 20 free mode, 22 free-in-two-digit
// RULE14 - Constant 21 shifts patterns left in free
// RULE15 - Six-digit register value shown signed, right-justified
// RULE16 - Out of range: display kept, error set
// RULE17 - Two-digit value 0..99 in rightmost two
// RULE18 - Free mode low byte sets rightmost segments
// RULE19 - Bits 0..6 segments a..g, bit 7 point
// RULE20 - Reset: blank, no points, six-digit, no zeros
// RULE21 - One command per strobe, applied next cycle
package ssd_pkg;

  // ************
  // Sizes and register map
  // ************
  localparam int NUM_DIGITS = 6;
  localparam int ADDR_W     = 8;
  localparam int BIN_W      = 20;
  localparam logic [ADDR_W-1:0] OFS_CMD_K  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD_R  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SEG_LO = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SEG_HI = 8'h10;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_LZ_BIT   = 2;
  localparam int STAT_FREE_BIT = 3;
  localparam int STAT_ERR_BIT  = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************
  // Constant commands and operand ranges
  // ************
  localparam logic [7:0] CMD_CLEAR = 8'h00;
  localparam logic [7:0] CMD_BAN1  = 8'h01;
  localparam logic [7:0] CMD_BAN2  = 8'h02;
  localparam logic [7:0] CMD_HELP  = 8'h03;
  localparam logic [7:0] CMD_HLPNN = 8'h04;
  localparam logic [7:0] CMD_ERROR = 8'h05;
  localparam logic [7:0] CMD_ERRNN = 8'h06;
  localparam logic [7:0] CMD_LZERO = 8'h07;
  localparam logic [7:0] CMD_TWO   = 8'h08;
  localparam logic [7:0] CMD_DP0   = 8'h0a;
  localparam logic [7:0] CMD_DP1   = 8'h0b;
  localparam logic [7:0] CMD_DP2   = 8'h0c;
  localparam logic [7:0] CMD_DP5   = 8'h0f;
  localparam logic [7:0] CMD_FREE  = 8'h14;
  localparam logic [7:0] CMD_SHIFT = 8'h15;
  localparam logic [7:0] CMD_FREE2 = 8'h16;
  localparam logic signed [31:0] NUM6_MIN = -32'sd99999;
  localparam logic signed [31:0] NUM6_MAX = 32'sd999999;
  localparam logic [31:0] NUM2_MAX = 32'd99;

  // ************
  // Segment patterns, bit 0 = a .. bit 6 = g, bit 7 = point
  // ************
  localparam logic [9:0][6:0] DIGIT_SEG = {7'h6f, 7'h7f, 7'h07, 7'h7d, 7'h6d,
                                           7'h66, 7'h4f, 7'h5b, 7'h06, 7'h3f};
  localparam logic [7:0] SEG_BLANK = 8'h00;
  localparam logic [7:0] SEG_MINUS = 8'h40;
  localparam logic [7:0] SEG_FULL  = 8'h7f;
  localparam logic [7:0] SEG_H = 8'h76;
  localparam logic [7:0] SEG_E = 8'h79;
  localparam logic [7:0] SEG_L = 8'h38;
  localparam logic [7:0] SEG_P = 8'h73;
  localparam logic [7:0] SEG_R = 8'h50;
  localparam logic [7:0] SEG_O = 8'h5c;
  // Banners, digit five first
  localparam logic [5:0][7:0] BAN_K1 = {SEG_MINUS, {4{SEG_FULL}}, SEG_MINUS};
  localparam logic [5:0][7:0] BAN_K2 = {{2{SEG_MINUS}}, {2{SEG_FULL}}, {2{SEG_MINUS}}};
  localparam logic [5:0][7:0] BAN_K3 = {{2{SEG_BLANK}}, SEG_H, SEG_E, SEG_L, SEG_P};
  localparam logic [5:0][7:0] BAN_K5 = {SEG_BLANK, SEG_E, SEG_R, SEG_R, SEG_O, SEG_R};
  localparam logic [3:0][7:0] PRE_K4 = {SEG_H, SEG_L, SEG_P, SEG_BLANK};
  localparam logic [3:0][7:0] PRE_K6 = {SEG_E, SEG_R, SEG_R, SEG_BLANK};

  // ************
  // Types
  // ************
  typedef enum logic [1:0] {
    MODE_SIX  = 2'b00,
    MODE_TWO  = 2'b01,
    MODE_FREE = 2'b10
  } ssd_mode_t;

  typedef struct packed {
    logic [NUM_DIGITS-1:0][6:0] seg;
    logic [NUM_DIGITS-1:0]      dp;
  } ssd_disp_t;

  typedef struct packed {
    logic                       aw_full;
    logic [ADDR_W-1:0]          aw_addr;
    logic                       w_full;
    logic [31:0]                w_data;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    ssd_mode_t                  mode;
    logic                       lz;
    logic                       free_en;
    logic                       err;
    logic [NUM_DIGITS-1:0][7:0] pat;
    logic [NUM_DIGITS-1:0]      dp;
    ssd_disp_t                  disp;
  } ssd_state_t;

  localparam ssd_state_t STATE_RST = '0;

endpackage

// >>> ssd_seg_enc.sv
// One decimal digit to seven-segment pattern
`timescale 1ns/1ps
module ssd_seg_enc
  import ssd_pkg::*;
(
  // Digit in, pattern out
  input  wire logic [3:0] digit_i,
  output      logic [6:0] seg_o
);

  // Codes above nine cannot arise from the converter; show blank
  always_comb begin
    seg_o = SEG_BLANK[6:0];
    if (digit_i <= 4'h9) begin
      seg_o = DIGIT_SEG[digit_i];
    end
  end

endmodule

// >>> ssd_bin2bcd.sv
// Binary magnitude to six decimal digits, shift-and-add-three
`timescale 1ns/1ps
module ssd_bin2bcd
  import ssd_pkg::*;
(
  // Magnitude in, digits out
  input  wire logic [BIN_W-1:0]           bin_i,
  output      logic [NUM_DIGITS-1:0][3:0] bcd_o
);

  // Fully combinational; values above 999999 wrap but are never shown
  always_comb begin
    logic [NUM_DIGITS*4-1:0] acc;
    acc = '0;
    for (int b = BIN_W - 1; b >= 0; b--) begin
      for (int d = 0; d < NUM_DIGITS; d++) begin
        if (acc[d*4 +: 4] >= 4'h5) begin
          acc[d*4 +: 4] = acc[d*4 +: 4] + 4'h3;
        end
      end
      acc = {acc[NUM_DIGITS*4-2:0], bin_i[b]};
    end
    bcd_o = acc;
  end

endmodule

// >>> ssd_cmd_monitor.sv
// Checker of handshakes and command effects of the display block
`timescale 1ns/1ps
module ssd_cmd_monitor
  import ssd_pkg::*;
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              arst_n_i,
  // Write side
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic [31:0]       s_axi_wdata_i,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic [1:0]        s_axi_bresp_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  // Read side
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic              s_axi_rvalid_o,
  // Display
  input wire ssd_disp_t         disp_o,
  input wire logic              err_o
);
  // Pair taken while no answer waits, so it runs at once
  wire       go   = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
                    && !s_axi_bvalid_o;
  wire       is_k = go && (s_axi_awaddr_i == OFS_CMD_K);
  wire [7:0] k    = s_axi_wdata_i[7:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  wr_answer_a: assert property (go |=> ##1 s_axi_bvalid_o)
    else $error("write answer late");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  disp_cause_a: assert property (!$stable(disp_o) |-> $rose(s_axi_bvalid_o))
    else $error("display moved without command");
  err_cause_a: assert property ($rose(err_o) |-> $rose(s_axi_bvalid_o))
    else $error("error set without command");
  reset_blank_a: assert property ($rose(arst_n_i) |-> disp_o == '0 && !err_o)
    else $error("not blank after reset");
  clear_cmd_a: assert property (is_k && k == CMD_CLEAR |=> ##1 disp_o == '0)
    else $error("clear left something lit");
  blank_cmd_a: assert property (is_k && (k == CMD_LZERO || k == CMD_TWO)
    |=> ##1 disp_o.seg == '0) else $error("blanking command left segments");
  dp_zero_a: assert property (is_k && k == CMD_DP0 |=> ##1 disp_o.dp[0])
    else $error("point zero not lit");
endmodule
bind ssd_cmd ssd_cmd_monitor mon_u (.*);

// >>> ssd_cpu_model.sv
// Bus master standing in for the processor that issues display commands
`timescale 1ns/1ps
module ssd_cpu_model
  import ssd_pkg::*;
(
  // Clock
  input  wire logic              clk_i,
  // Write side
  output      logic [ADDR_W-1:0] s_axi_awaddr_i,
  output      logic              s_axi_awvalid_i,
  input  wire logic              s_axi_awready_o,
  output      logic [31:0]       s_axi_wdata_i,
  output      logic [3:0]        s_axi_wstrb_i,
  output      logic              s_axi_wvalid_i,
  input  wire logic              s_axi_wready_o,
  input  wire logic [1:0]        s_axi_bresp_o,
  input  wire logic              s_axi_bvalid_o,
  output      logic              s_axi_bready_i,
  // Read side
  output      logic [ADDR_W-1:0] s_axi_araddr_i,
  output      logic              s_axi_arvalid_i,
  input  wire logic              s_axi_arready_o,
  input  wire logic [31:0]       s_axi_rdata_o,
  input  wire logic [1:0]        s_axi_rresp_o,
  input  wire logic              s_axi_rvalid_o,
  output      logic              s_axi_rready_i
);
  logic slow = 1'b0; // Holds write answers off two cycles
  // Idle bus at time zero
  initial {s_axi_awaddr_i, s_axi_awvalid_i, s_axi_wdata_i, s_axi_wstrb_i, s_axi_wvalid_i,
           s_axi_bready_i, s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} = '0;

  // One command per write, constant or register word by address
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= 4'hf;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= !slow;
    while (!(ad && dd)) begin
      @(posedge clk_i);
      if (!ad && s_axi_awready_o) begin
        ad = 1'b1;
        s_axi_awvalid_i <= 1'b0;
        s_axi_awaddr_i <= ~a; // Released lines show no stale value
      end
      if (!dd && s_axi_wready_o) begin
        dd = 1'b1;
        s_axi_wvalid_i <= 1'b0;
        s_axi_wdata_i <= ~d;
      end
    end
    if (slow) begin
      repeat (2) @(posedge clk_i);
      s_axi_bready_i <= 1'b1;
    end
    do @(posedge clk_i); while (!s_axi_bvalid_o);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  // Single read, answer taken at the edge where it is seen
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    s_axi_araddr_i <= ~a;
    while (!s_axi_rvalid_o) @(posedge clk_i);
    q = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask
endmodule

// >>> seven_segment_display_command_test.sv
// Self-checking bench of the display command block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module seven_segment_display_command_test
  import ssd_pkg::*;
();
  logic              clk_i = 1'b0;
  logic              arst_n_i = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]       s_axi_wdata_i, s_axi_rdata_o, q;
  logic [3:0]        s_axi_wstrb_i;
  logic [1:0]        s_axi_bresp_o, s_axi_rresp_o, r;
  logic              s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic              s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic              s_axi_rvalid_o, s_axi_rready_i, err_o;
  ssd_disp_t         disp_o;
  int                err_total = 0;
  int                tests_run = 0;
  localparam logic [3:0][7:0]  KB = {CMD_ERROR, CMD_HELP, CMD_BAN2, CMD_BAN1};
  localparam logic [3:0][47:0] BB = {BAN_K5, BAN_K3, BAN_K2, BAN_K1};

  ssd_cmd       dut_u (.*);
  ssd_cpu_model cpu_u (.*);
  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // ************
  // Shared steps
  // ************
  task automatic cmd(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    cpu_u.wr(a, d, r);
    `CHK("bresp", RESP_OKAY, r)
  endtask
  task automatic mode(input logic [1:0] m);
    cpu_u.rd(OFS_STATUS, q, r);
    `CHK("mode", m, q[1:0])
  endtask
  // Drops the point bit of each digit pattern
  function automatic logic [41:0] strip(input logic [5:0][7:0] x);
    for (int i = 0; i < 6; i++) strip[7*i +: 7] = x[i][6:0];
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ************
  // Scenarios
  // ************
  task automatic t_text();
    mode(MODE_SIX);
    `CHK("rst", 80'h0, {q, disp_o})
    for (int i = 0; i < 4; i++) begin
      cmd(OFS_CMD_K, CMD_TWO);
      cmd(OFS_CMD_K, KB[i]);
      `CHK("banner", strip(BB[i]), disp_o.seg)
      mode(MODE_SIX);
    end
    cmd(OFS_CMD_K, CMD_HLPNN);
    `CHK("k4", strip({PRE_K4, 16'h0}), disp_o.seg)
    cmd(OFS_CMD_K, CMD_ERRNN);
    mode(MODE_TWO);
    cmd(OFS_CMD_R, 32'd42);
    `CHK("r42", strip({PRE_K6, 1'b0, DIGIT_SEG[4], 1'b0, DIGIT_SEG[2]}), disp_o.seg)
    cmd(OFS_CMD_R, 32'd100);
    `CHK("err", 1'b1, err_o)
    `CHK("keep", strip({PRE_K6, 1'b0, DIGIT_SEG[4], 1'b0, DIGIT_SEG[2]}), disp_o.seg)
    cmd(OFS_STATUS, 32'h10);
    `CHK("errclr", 1'b0, err_o)
    $display("t_text done");
  endtask

  task automatic t_six();
    cpu_u.slow = 1'b1;
    cmd(OFS_CMD_K, CMD_CLEAR);
    cmd(OFS_CMD_R, -32'sd99999);
    `CHK("min", strip({SEG_MINUS, {5{1'b0, DIGIT_SEG[9]}}}), disp_o.seg)
    cpu_u.rd(OFS_SEG_HI, q, r);
    `CHK("seghi", 32'h406f, q)
    cmd(OFS_CMD_R, 32'd999999);
    `CHK("max", strip({6{1'b0, DIGIT_SEG[9]}}), disp_o.seg)
    cmd(OFS_CMD_R, 32'd1000000);
    `CHK("over", {1'b1, strip({6{1'b0, DIGIT_SEG[9]}})}, {err_o, disp_o.seg})
    cmd(OFS_CMD_K, CMD_LZERO);
    cmd(OFS_CMD_R, 32'd7);
    `CHK("lz", strip({{5{1'b0, DIGIT_SEG[0]}}, 1'b0, DIGIT_SEG[7]}), disp_o.seg)
    cpu_u.slow = 1'b0;
    cmd(OFS_STATUS, 32'h10);
    $display("t_six done");
  endtask

  task automatic t_point();
    cmd(OFS_CMD_K, CMD_CLEAR);
    for (int i = 10; i < 16; i++) cmd(OFS_CMD_K, 8'(i));
    `CHK("dp6", 6'h3f, disp_o.dp)
    cmd(OFS_CMD_K, CMD_CLEAR);
    `CHK("dpclr", 6'h00, disp_o.dp)
    cmd(OFS_CMD_K, CMD_TWO);
    for (int i = 15; i > 9; i--) cmd(OFS_CMD_K, 8'(i));
    `CHK("dp2", 6'h03, disp_o.dp)
    mode(MODE_TWO);
    $display("t_point done");
  endtask

  task automatic t_free();
    cmd(OFS_CMD_K, CMD_CLEAR);
    cmd(OFS_CMD_K, CMD_FREE);
    mode(MODE_FREE);
    cmd(OFS_CMD_R, 32'h75);
    `CHK("free", 8'hea, {disp_o.seg[0], disp_o.dp[0]})
    cmd(OFS_CMD_R, 32'h86);
    cmd(OFS_CMD_K, CMD_SHIFT);
    `CHK("shift", 16'h0c02, {disp_o.seg[1:0], disp_o.dp[1:0]})
    cpu_u.rd(OFS_SEG_LO, q, r);
    `CHK("seglo", 32'h8600, q)
    cmd(OFS_CMD_K, CMD_FREE2);
    cpu_u.rd(OFS_STATUS, q, r);
    `CHK("free2", 4'h9, q[3:0])
    cpu_u.wr(8'h14, 32'h1, r);
    `CHK("wresp", RESP_SLVERR, r)
    cpu_u.rd(8'h14, q, r);
    `CHK("rresp", {RESP_SLVERR, 32'h0}, {r, q})
    $display("t_free done");
  endtask

  // Watchdog far past the run's length
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_text();
    t_six();
    t_point();
    t_free();
    test_done();
  end
endmodule
